/* File: lsf_params.svh */
// Constants for the layer 2 port security filter.
// Assumes inclusion before any module that uses the filter's offsets and codes.
`ifndef LSF_PARAMS_SVH
`define LSF_PARAMS_SVH
`define LSF_NUM_PORTS 8
`define LSF_LIMIT_W 8
`define LSF_LIMIT_UNLIMITED 8'hff
`define LSF_EAPOL_DA 48'h0180c2000003
`define LSF_EAPOL_TYPE 16'h888e
// Register offsets; each per-port register is base plus port index
`define LSF_ADDR_W 8
`define LSF_OFF_GLOBAL 8'h00
`define LSF_OFF_STATUS 8'h01
`define LSF_OFF_PCTRL 8'h10
`define LSF_OFF_LIMIT 8'h20
`define LSF_OFF_COUNT 8'h30
// Global register fields
`define LSF_G_AUTH_EN 0
`define LSF_G_STP_EN 1
`define LSF_G_LIM_MODE 2
`define LSF_G_SPF_MODE 3
`define LSF_G_LOCK_DROP 4
`define LSF_G_MGMT_LO 8
`define LSF_G_MGMT_HI 10
`define LSF_GLOBAL_RST 32'h0000_0000
// Per-port control fields
`define LSF_P_AUTH_LO 0
`define LSF_P_AUTH_HI 1
`define LSF_P_LRN_DIS 2
`define LSF_P_LIM_EN 3
`define LSF_P_LOCK_EN 4
`define LSF_P_SPF_EN 5
`define LSF_PCTRL_RST 8'h03
`define LSF_LIMIT_RST 8'hff
`endif

/* File: lsf_pkg.sv */
// Types shared by the layer 2 port security filter.
// Assumes lsf_params.svh is compiled first.
`default_nettype none
`include "lsf_params.svh"
package lsf_pkg;
  typedef enum logic [1:0] {
    LSF_AUTH_NONE,
    LSF_AUTH_INGRESS,
    LSF_AUTH_EGRESS,
    LSF_AUTH_FULL
  } lsf_auth_e;

  typedef struct packed {
    logic [2:0] in_port;
    logic [47:0] da;
    logic [15:0] ether_type;
    logic sa_unicast;
    logic sa_hit;
    logic sa_static;
    logic [2:0] sa_port;
    logic [11:0] sa_vid;
    logic [11:0] in_vid;
    logic [7:0] dest_map;
    logic [7:0] stp_fwd_map;
  } lsf_frame_s;

  typedef struct packed {
    logic drop;
    logic learn;
    logic refresh;
    logic [7:0] dest_map;
    logic eapol;
    logic lim_viol;
    logic lock_viol;
    logic spf_viol;
  } lsf_verdict_s;
endpackage
`default_nettype wire

/* File: lsf_filter.sv */
// Per-port layer 2 security decision for each received frame.
// Assumes frames arrive as one-cycle descriptors with the table lookup already done.
//
// Overview of operation
// - Unauthorized port drops regular frames, no learning, excluded from destinations.
// - Ingress-only port accepts frames but is never a destination.
// - Egress-only port drops received regular frames, remains a destination.
// - Fully authorized port passes traffic unrestricted.
// - EAPOL frames bypass authorization state in restricted states.
// - Authorization applies only while spanning-tree state is forwarding.
// - EAPOL means DA 01:80:C2:00:00:03 and EtherType 888E.
// - With authorization on, EAPOL goes to the management port.
// - Learn-disable bit stops learning, skips limit check, never drops.
// - Port reaching its limit stops learning only on that port.
// - Limit violation flagged, not learned; mode bit chooses drop or forward.
// - Refresh of stored address at limit is no violation.
// - Limit 255 means unlimited learning, no limit drops.
// - Limit zero disables learning; lookup still happens.
// - Limit changes at run time; lowering flushes nothing.
// - Source stored on other locked port is a locking violation.
// - Spoof detection flags any source stored on another port.
// - Address may move to port with spoofing detection off.
// - Without limitation, only table capacity bounds learning.
// - Static entries never modified by dynamic learning.
//
// Chosen here: the register offsets and the address-and-strobe port.
`default_nettype none
`include "lsf_params.svh"
module lsf_filter
  import lsf_pkg::*;
#(
  parameter int NUM_PORTS = `LSF_NUM_PORTS,
  parameter int LIMIT_W = `LSF_LIMIT_W
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [`LSF_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic frame_valid_i,
  input wire lsf_frame_s frame_i,
  input wire logic age_out_valid_i,
  input wire logic [2:0] age_out_port_i,
  output logic verdict_valid_o,
  output lsf_verdict_s verdict_o
);
  logic [31:0] global_ctrl_zero_reg;
  logic [7:0] port_ctrl_reg [NUM_PORTS];
  logic [LIMIT_W-1:0] port_learn_limit [NUM_PORTS];
  logic [LIMIT_W-1:0] learn_count_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] lim_sticky_reg;
  logic [NUM_PORTS-1:0] lock_sticky_reg;
  logic [NUM_PORTS-1:0] spf_sticky_reg;

  logic auth_en;
  logic stp_en;
  logic limit_violation_mode;
  logic spoof_violation_mode;
  logic lock_drop;
  logic [2:0] mgmt_port;
  assign auth_en = global_ctrl_zero_reg[`LSF_G_AUTH_EN];
  assign stp_en = global_ctrl_zero_reg[`LSF_G_STP_EN];
  assign limit_violation_mode = global_ctrl_zero_reg[`LSF_G_LIM_MODE];
  assign spoof_violation_mode = global_ctrl_zero_reg[`LSF_G_SPF_MODE];
  assign lock_drop = global_ctrl_zero_reg[`LSF_G_LOCK_DROP];
  assign mgmt_port = global_ctrl_zero_reg[`LSF_G_MGMT_HI:`LSF_G_MGMT_LO];

  // Per-port authorization decode; both directions side by side
  logic [NUM_PORTS-1:0] rx_allowed;
  logic [NUM_PORTS-1:0] tx_allowed;

  always_comb begin
    rx_allowed = '0;
    tx_allowed = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      case (lsf_auth_e'(port_ctrl_reg[p][`LSF_P_AUTH_HI:`LSF_P_AUTH_LO]))
        LSF_AUTH_NONE: begin
          rx_allowed[p] = 1'b0;
          tx_allowed[p] = 1'b0;
        end
        LSF_AUTH_INGRESS: begin
          rx_allowed[p] = 1'b1;
          tx_allowed[p] = 1'b0;
        end
        LSF_AUTH_EGRESS: begin
          rx_allowed[p] = 1'b0;
          tx_allowed[p] = 1'b1;
        end
        LSF_AUTH_FULL: begin
          rx_allowed[p] = 1'b1;
          tx_allowed[p] = 1'b1;
        end
        default: begin
          rx_allowed[p] = 1'b0;
          tx_allowed[p] = 1'b0;
        end
      endcase
    end
  end

  // Register address decode, shared by writes, clears and reads
  logic sel_global;
  logic sel_status;
  logic [NUM_PORTS-1:0] sel_pctrl;
  logic [NUM_PORTS-1:0] sel_limit;
  logic [NUM_PORTS-1:0] sel_count;

  always_comb begin
    sel_global = (reg_addr_i == `LSF_OFF_GLOBAL);
    sel_status = (reg_addr_i == `LSF_OFF_STATUS);
    sel_pctrl = '0;
    sel_limit = '0;
    sel_count = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      sel_pctrl[p] = (reg_addr_i == `LSF_OFF_PCTRL + 8'(p));
      sel_limit[p] = (reg_addr_i == `LSF_OFF_LIMIT + 8'(p));
      sel_count[p] = (reg_addr_i == `LSF_OFF_COUNT + 8'(p));
    end
  end

  // Frame decision, combinational
  logic [7:0] in_ctrl;
  logic [7:0] st_ctrl;
  logic [LIMIT_W-1:0] in_limit;
  logic [LIMIT_W-1:0] in_count;
  logic auth_active;
  logic is_eapol;
  logic learn_disable_bit;
  logic spoof_detect_ctrl_bit;
  logic other_port;
  logic lock_v;
  logic spf_v;
  logic new_addr;
  logic lim_v;
  logic auth_drop;
  logic drop_c;
  logic learn_c;
  logic refresh_c;
  logic [7:0] dest_c;

  always_comb begin
    in_ctrl = port_ctrl_reg[frame_i.in_port];
    st_ctrl = port_ctrl_reg[frame_i.sa_port];
    in_limit = port_learn_limit[frame_i.in_port];
    in_count = learn_count_reg[frame_i.in_port];
    learn_disable_bit = in_ctrl[`LSF_P_LRN_DIS];
    spoof_detect_ctrl_bit = in_ctrl[`LSF_P_SPF_EN];
    is_eapol = (frame_i.da == `LSF_EAPOL_DA) && (frame_i.ether_type == `LSF_EAPOL_TYPE);
    auth_active = auth_en && (!stp_en || frame_i.stp_fwd_map[frame_i.in_port]);
    other_port = frame_i.sa_hit && (frame_i.sa_port != frame_i.in_port);
    lock_v = other_port && st_ctrl[`LSF_P_LOCK_EN];
    spf_v = other_port && spoof_detect_ctrl_bit;
    // Refresh or move needs no new entry
    new_addr = !frame_i.sa_hit;
    lim_v = frame_i.sa_unicast && !learn_disable_bit && in_ctrl[`LSF_P_LIM_EN] && new_addr &&
            (in_limit != `LSF_LIMIT_UNLIMITED) && (in_count >= in_limit);
    auth_drop = 1'b0;
    dest_c = frame_i.dest_map;
    if (auth_active) begin
      dest_c = frame_i.dest_map & 8'(tx_allowed);
      auth_drop = !rx_allowed[frame_i.in_port];
      if (is_eapol) begin
        auth_drop = 1'b0;
        dest_c = 8'h00;
        dest_c[mgmt_port] = 1'b1;
      end
    end
    drop_c = auth_drop || (lim_v && !limit_violation_mode) || (lock_v && lock_drop) ||
             (spf_v && spoof_violation_mode);
    learn_c = frame_i.sa_unicast && !learn_disable_bit && !auth_drop && !lim_v && !lock_v && !spf_v &&
              !(frame_i.sa_hit && frame_i.sa_static);
    refresh_c = learn_c && frame_i.sa_hit && !other_port && (frame_i.sa_vid == frame_i.in_vid);
    if (drop_c) begin
      dest_c = 8'h00;
    end
  end

  // Idle verdict is all zero so stale fields never look like a decision
  lsf_verdict_s verdict_next;

  always_comb begin
    verdict_next = '0;
    if (frame_valid_i) begin
      verdict_next.drop = drop_c;
      verdict_next.learn = learn_c;
      verdict_next.refresh = refresh_c;
      verdict_next.dest_map = dest_c;
      verdict_next.eapol = is_eapol;
      verdict_next.lim_viol = lim_v;
      verdict_next.lock_viol = lock_v;
      verdict_next.spf_viol = spf_v;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      verdict_valid_o <= 1'b0;
      verdict_o <= '0;
    end else begin
      verdict_valid_o <= frame_valid_i;
      verdict_o <= verdict_next;
    end
  end

  // Learned address counters per port; aging is the only way down
  // A learn and an age-out in one cycle cancel unless the count is at zero or full; both ends saturate
  logic [NUM_PORTS-1:0] cnt_inc;
  logic [NUM_PORTS-1:0] cnt_dec;
  logic [LIMIT_W-1:0] learn_count_next [NUM_PORTS];

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      cnt_inc[p] = frame_valid_i && learn_c && new_addr && (frame_i.in_port == 3'(p)) &&
                   (learn_count_reg[p] != {LIMIT_W{1'b1}});
      cnt_dec[p] = age_out_valid_i && (age_out_port_i == 3'(p)) && (learn_count_reg[p] != '0);
      if (cnt_inc[p] && !cnt_dec[p]) begin
        learn_count_next[p] = learn_count_reg[p] + 1'b1;
      end else if (cnt_dec[p] && !cnt_inc[p]) begin
        learn_count_next[p] = learn_count_reg[p] - 1'b1;
      end else begin
        learn_count_next[p] = learn_count_reg[p];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        learn_count_reg[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        learn_count_reg[p] <= learn_count_next[p];
      end
    end
  end

  // Configuration writes
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      global_ctrl_zero_reg <= `LSF_GLOBAL_RST;
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_ctrl_reg[p] <= `LSF_PCTRL_RST;
        port_learn_limit[p] <= `LSF_LIMIT_RST;
      end
    end else if (reg_wr_i) begin
      if (sel_global) begin
        global_ctrl_zero_reg <= reg_wdata_i;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (sel_pctrl[p]) begin
          port_ctrl_reg[p] <= reg_wdata_i[7:0];
        end
        if (sel_limit[p]) begin
          port_learn_limit[p] <= reg_wdata_i[LIMIT_W-1:0];
        end
      end
    end
  end

  // Sticky flags, set beats clear
  // A clear racing a new violation must not lose the event
  logic [NUM_PORTS-1:0] viol_port;
  logic [NUM_PORTS-1:0] lim_clr;
  logic [NUM_PORTS-1:0] lock_clr;
  logic [NUM_PORTS-1:0] spf_clr;
  logic [NUM_PORTS-1:0] lim_sticky_next;
  logic [NUM_PORTS-1:0] lock_sticky_next;
  logic [NUM_PORTS-1:0] spf_sticky_next;

  always_comb begin
    viol_port = '0;
    viol_port[frame_i.in_port] = frame_valid_i;
    lim_clr = '0;
    lock_clr = '0;
    spf_clr = '0;
    if (reg_wr_i && sel_status) begin
      lim_clr = reg_wdata_i[NUM_PORTS-1:0];
      lock_clr = reg_wdata_i[8+NUM_PORTS-1:8];
      spf_clr = reg_wdata_i[16+NUM_PORTS-1:16];
    end
    lim_sticky_next = (lim_sticky_reg & ~lim_clr) | (viol_port & {NUM_PORTS{lim_v}});
    lock_sticky_next = (lock_sticky_reg & ~lock_clr) | (viol_port & {NUM_PORTS{lock_v}});
    spf_sticky_next = (spf_sticky_reg & ~spf_clr) | (viol_port & {NUM_PORTS{spf_v}});
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lim_sticky_reg <= '0;
      lock_sticky_reg <= '0;
      spf_sticky_reg <= '0;
    end else begin
      lim_sticky_reg <= lim_sticky_next;
      lock_sticky_reg <= lock_sticky_next;
      spf_sticky_reg <= spf_sticky_next;
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    if (reg_rd_i) begin
      if (sel_global) begin
        rdata_next = global_ctrl_zero_reg;
      end
      if (sel_status) begin
        rdata_next = {8'h00, 8'(spf_sticky_reg), 8'(lock_sticky_reg), 8'(lim_sticky_reg)};
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (sel_pctrl[p]) begin
          rdata_next = {24'h0, port_ctrl_reg[p]};
        end
        if (sel_limit[p]) begin
          rdata_next = 32'(port_learn_limit[p]);
        end
        if (sel_count[p]) begin
          rdata_next = 32'(learn_count_reg[p]);
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end
endmodule
`default_nettype wire

/* File: lsf_filter_checker.sv */
// Port assertions for the layer 2 port security filter.
// Assumes one clock domain and the design's registered verdict.
`default_nettype none
`include "lsf_params.svh"
module lsf_filter_checker
  import lsf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic frame_valid_i,
  input wire lsf_frame_s frame_i,
  input wire logic verdict_valid_o,
  input wire lsf_verdict_s verdict_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_verdict_next_cycle: assert property (frame_valid_i |=> verdict_valid_o)
    else $error("verdict missing");
  a_no_stray_verdict: assert property (!frame_valid_i |=> !verdict_valid_o)
    else $error("stray verdict");
  a_idle_verdict_zero: assert property (!verdict_valid_o |-> verdict_o == '0)
    else $error("verdict not zero");
  a_drop_empty_dest: assert property (verdict_valid_o && verdict_o.drop |-> verdict_o.dest_map == 8'h00)
    else $error("dropped frame has destinations");
  a_violation_no_learn: assert property (verdict_valid_o && (verdict_o.lim_viol || verdict_o.lock_viol
    || verdict_o.spf_viol) |-> !verdict_o.learn)
    else $error("violating address learned");
  a_eapol_class_match: assert property (frame_valid_i |=> verdict_o.eapol == ($past(frame_i.da) == `LSF_EAPOL_DA
    && $past(frame_i.ether_type) == `LSF_EAPOL_TYPE))
    else $error("eapol class wrong");
  a_static_never_learn: assert property (frame_valid_i && frame_i.sa_static |=> !verdict_o.learn)
    else $error("static entry learned");
  a_dest_never_added: assert property (frame_valid_i ##1 !verdict_o.eapol
    |-> (verdict_o.dest_map & ~$past(frame_i.dest_map)) == 8'h00)
    else $error("destination added");
  a_read_data_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside window");
endmodule
bind lsf_filter lsf_filter_checker chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
  .verdict_valid_o(verdict_valid_o), .verdict_o(verdict_o));
`default_nettype wire

/* File: lsf_port_model.sv */
// Ingress frame path model: hands one descriptor over, takes its verdict.
// Assumes the bench calls send from one process only.
`default_nettype none
module lsf_port_model
  import lsf_pkg::*;
(
  input wire logic mclk_i,
  output var logic frame_valid_o,
  output var lsf_frame_s frame_o,
  input wire logic verdict_valid_i,
  input wire lsf_verdict_s verdict_i
);
  initial begin
    frame_valid_o = 1'b0;
    frame_o = '0;
  end
  // Inverted descriptor when idle, so stale fields cannot pass
  task automatic send(input lsf_frame_s f, output logic ok, output lsf_verdict_s v);
    @(posedge mclk_i);
    frame_valid_o <= 1'b1;
    frame_o <= f;
    @(posedge mclk_i);
    frame_valid_o <= 1'b0;
    frame_o <= ~f;
    #1;
    ok = verdict_valid_i;
    v = verdict_i;
  endtask
endmodule
`default_nettype wire

/* File: tb_lsf_filter.sv */
// Self-checking bench for the layer 2 port security filter.
// Assumes the package, checker bind and port model compile first.
`default_nettype none
`include "lsf_params.svh"
module tb_lsf_filter
  import lsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic age_out_valid_i = 1'b0;
  logic [2:0] age_out_port_i = 3'h0;
  logic [31:0] reg_rdata_o;
  logic frame_valid_i, verdict_valid_o;
  lsf_frame_s frame_i, f;
  lsf_verdict_s verdict_o, v;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 mclk_i = ~mclk_i;
  lsf_filter dut (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .frame_valid_i, .frame_i, .age_out_valid_i, .age_out_port_i, .verdict_valid_o, .verdict_o);
  lsf_port_model pm (.mclk_i(mclk_i), .frame_valid_o(frame_valid_i), .frame_o(frame_i),
    .verdict_valid_i(verdict_valid_o), .verdict_i(verdict_o));
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    reg_addr_i <= ~a;
    #1;
    chk(reg_rdata_o, e);
  endtask
  task automatic age(input logic [2:0] p);
    @(posedge mclk_i);
    age_out_valid_i <= 1'b1;
    age_out_port_i <= p;
    @(posedge mclk_i);
    age_out_valid_i <= 1'b0;
  endtask
  task automatic snd();
    logic ok;
    pm.send(f, ok, v);
    chk(32'(ok), 32'h1);
  endtask
  task automatic fx(input logic d, input logic l, input logic [2:0] vi, input logic [7:0] m);
    snd();
    chk(32'({v.drop, v.learn, v.lim_viol, v.lock_viol, v.spf_viol, v.dest_map}), 32'({d, l, vi, m}));
  endtask
  function automatic lsf_frame_s base(input logic [2:0] p);
    base = '0;
    base.in_port = p;
    base.da = 48'h0000_0000_0a01;
    base.ether_type = 16'h0800;
    base.sa_unicast = 1'b1;
    base.dest_map = 8'h0c;
    base.stp_fwd_map = 8'hff;
  endfunction
  task automatic t_reset();
    rc(8'h10, 32'h3);
    rc(8'h20, 32'hff);
    rc(8'h00, 32'h0);
    rc(8'h30, 32'h0);
    rc(8'h7f, 32'h0);
  endtask
  task automatic t_auth();
    logic d;
    wr(8'h00, 32'h0701);
    for (int a = 0; a < 4; a++) begin
      wr(8'h11, 32'(a));
      wr(8'h12, 32'(a));
      d = (a == 0 || a == 2);
      f = base(3'h1);
      fx(d, !d, 3'b000, d ? 8'h00 : (a == 1 ? 8'h08 : 8'h0c));
      f.da = `LSF_EAPOL_DA;
      f.ether_type = `LSF_EAPOL_TYPE;
      snd();
      chk(32'({v.drop, v.eapol, v.dest_map}), 32'h180);
    end
  endtask
  task automatic t_stp();
    wr(8'h11, 32'h0);
    wr(8'h00, 32'h0703);
    f = base(3'h1);
    f.stp_fwd_map = 8'hfd;
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    f.stp_fwd_map = 8'hff;
    f.da = `LSF_EAPOL_DA;
    f.ether_type = 16'h888f;
    fx(1'b1, 1'b0, 3'b000, 8'h00);
  endtask
  task automatic t_limit();
    wr(8'h00, 32'h0701);
    wr(8'h15, 32'h0b);
    wr(8'h25, 32'h2);
    f = base(3'h5);
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    rc(8'h35, 32'h2);
    fx(1'b1, 1'b0, 3'b100, 8'h00);
    f.in_port = 3'h6;
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    f.in_port = 3'h5;
    wr(8'h00, 32'h0705);
    fx(1'b0, 1'b0, 3'b100, 8'h0c);
    rc(8'h01, 32'h20);
    wr(8'h01, 32'h20);
    rc(8'h01, 32'h0);
    f.sa_hit = 1'b1;
    f.sa_port = 3'h5;
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    chk(32'(v.refresh), 32'h1);
    f.sa_hit = 1'b0;
    wr(8'h25, 32'h0);
    fx(1'b0, 1'b0, 3'b100, 8'h0c);
    rc(8'h35, 32'h2);
    wr(8'h25, 32'h3);
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    wr(8'h25, 32'hff);
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    wr(8'h25, 32'h0);
    wr(8'h15, 32'h0f);
    fx(1'b0, 1'b0, 3'b000, 8'h0c);
    rc(8'h35, 32'h4);
    age(3'h5);
    rc(8'h35, 32'h3);
  endtask
  task automatic t_lock();
    wr(8'h00, 32'h0719);
    wr(8'h11, 32'h03);
    wr(8'h14, 32'h13);
    f = base(3'h1);
    f.sa_hit = 1'b1;
    f.sa_port = 3'h4;
    fx(1'b1, 1'b0, 3'b010, 8'h00);
    wr(8'h14, 32'h03);
    wr(8'h11, 32'h23);
    fx(1'b1, 1'b0, 3'b001, 8'h00);
    rc(8'h01, 32'h00020220);
    wr(8'h11, 32'h03);
    fx(1'b0, 1'b1, 3'b000, 8'h0c);
    f.sa_static = 1'b1;
    fx(1'b0, 1'b0, 3'b000, 8'h0c);
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_auth();
    t_stp();
    t_limit();
    t_lock();
    results();
  end
  // Whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
endmodule
`default_nettype wire
